/* File: tdcc_pkg.sv */
// constants, carriers and helpers for the dual capture/compare timer
package tdcc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] IDX_FIRST = 4'h0;
	localparam logic [ADDR_W-1:0] IDX_SECOND = 4'h1;
	localparam logic [ADDR_W-1:0] IDX_COUNTER = 4'h2;
	localparam logic [ADDR_W-1:0] IDX_MODE = 4'h3;
	localparam logic [ADDR_W-1:0] IDX_CTL = 4'h4;
	localparam logic [ADDR_W-1:0] IDX_PRE = 4'h5;
	localparam int CTL_FIRST_SEL = 0;
	localparam int CTL_FIRST_SRC = 1;
	localparam int CTL_SECOND_SEL = 2;
	localparam int CTL_OUT_EN = 3;
	localparam int MODE_OVF = 0;
	localparam int MODE_LO = 2;
	localparam int MODE_OSPT = 4;
	localparam int PRE_CLK_LO = 0;
	localparam int PRE_PRI_LO = 4;
	localparam int PRE_SEC_LO = 6;
	localparam logic [1:0] MODE_STOP = 2'h0;
	localparam logic [1:0] MODE_FREE = 2'h1;
	localparam logic [1:0] MODE_CLR_EDGE = 2'h2;
	localparam logic [1:0] MODE_CLR_MATCH = 2'h3;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE = 16'h0001;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} tdcc_bus_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] first;
		logic [15:0] second;
		logic [1:0] mode;
		logic ovf;
		logic [3:0] ctl;
		logic [1:0] pri_edge;
		logic [1:0] sec_edge;
		logic [1:0] clk_sel;
		logic [2:0] div;
		logic irq1;
		logic irq2;
		logic tout;
		logic toe;
		logic [15:0] rdata;
	} tdcc_state_t;

	typedef struct packed {
		logic meta;
		logic stable;
		logic prev;
	} tdcc_sync_t;

	// the reserved code 10 selects no edge at all
	function automatic logic tdcc_edge_hit(input logic [1:0] sel, input logic rise,
		input logic fall);
		logic hit;
		hit = 1'b0;
		case (sel)
			EDGE_FALL: hit = fall;
			EDGE_RISE: hit = rise;
			EDGE_BOTH: hit = rise | fall;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction
endpackage

/* File: tdcc_edge_sync.sv */
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module tdcc_edge_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	tdcc_pkg::tdcc_sync_t st_q;
	tdcc_pkg::tdcc_sync_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.meta = pin;
		st_d.stable = st_q.meta;
		st_d.prev = st_q.stable;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// edges compare the second stage with its delayed copy, never the metastable one
	assign rise = st_q.stable & ~st_q.prev;
	assign fall = ~st_q.stable & st_q.prev;
endmodule

/* File: tdcc_timer.sv */
// 16-bit up-counter with two capture/compare registers and register port
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module tdcc_timer (
	input wire logic clk,
	input wire logic sys_rst,
	input wire tdcc_pkg::tdcc_bus_t bus,
	output logic [tdcc_pkg::DATA_W-1:0] rdata,
	input wire logic primary_timer_input,
	input wire logic secondary_timer_input,
	output logic first_match_irq,
	output logic second_match_irq,
	output logic timer_output_pin,
	output logic timer_output_oe
);
	tdcc_pkg::tdcc_state_t st_q;
	tdcc_pkg::tdcc_state_t st_d;

	logic pri_rise;
	logic pri_fall;
	logic sec_rise;
	logic sec_fall;
	logic running;
	logic [2:0] div_mask;
	logic tick;
	logic pri_valid;
	logic sec_valid;
	logic first_cap;
	logic second_cap;
	logic first_is_cap;
	logic second_is_cap;
	logic first_from_pri;
	logic sec_as_input;
	logic ospt_req;
	logic clr_now;
	logic match1;
	logic match2;
	logic wr_first;
	logic wr_second;
	logic wr_mode;
	logic wr_ctl;
	logic wr_pre;

	tdcc_edge_sync u_pri_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin(primary_timer_input),
		.rise(pri_rise),
		.fall(pri_fall)
	);

	tdcc_edge_sync u_sec_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin(secondary_timer_input),
		.rise(sec_rise),
		.fall(sec_fall)
	);

	// register decode
	assign wr_first = bus.wr && (bus.addr == tdcc_pkg::IDX_FIRST);
	assign wr_second = bus.wr && (bus.addr == tdcc_pkg::IDX_SECOND);
	assign wr_mode = bus.wr && (bus.addr == tdcc_pkg::IDX_MODE);
	assign wr_ctl = bus.wr && (bus.addr == tdcc_pkg::IDX_CTL);
	assign wr_pre = bus.wr && (bus.addr == tdcc_pkg::IDX_PRE);

	// count clock: one-cycle enable from a power-of-two divider
	assign running = (st_q.mode != tdcc_pkg::MODE_STOP);
	assign div_mask = 3'((4'h1 << st_q.clk_sel) - 4'h1);
	assign tick = running && ((st_q.div & div_mask) == div_mask);

	// capture/compare role of each register
	assign first_is_cap = st_q.ctl[tdcc_pkg::CTL_FIRST_SEL];
	assign second_is_cap = st_q.ctl[tdcc_pkg::CTL_SECOND_SEL];
	assign first_from_pri = st_q.ctl[tdcc_pkg::CTL_FIRST_SRC];

	// shared pin: secondary input ignored while it drives the timer output
	assign sec_as_input = !st_q.toe;

	// primary valid edge, used for clear mode and second-register capture
	assign pri_valid = tdcc_pkg::tdcc_edge_hit(st_q.pri_edge, pri_rise, pri_fall);
	assign sec_valid = sec_as_input
		&& tdcc_pkg::tdcc_edge_hit(st_q.sec_edge, sec_rise, sec_fall);

	// primary trigger for the first register is the opposite edge, both gives none
	always_comb begin
		first_cap = 1'b0;
		if (first_is_cap) begin
			if (first_from_pri) begin
				if (st_q.pri_edge != tdcc_pkg::EDGE_BOTH) begin
					first_cap = tdcc_pkg::tdcc_edge_hit(st_q.pri_edge, pri_fall, pri_rise);
				end
			end else begin
				first_cap = sec_valid;
			end
		end
	end

	assign second_cap = second_is_cap && pri_valid;

	// one-shot software trigger clears the counter while it runs
	assign ospt_req = wr_mode && bus.wdata[tdcc_pkg::MODE_OSPT];
	assign clr_now = running && (ospt_req
		|| ((st_q.mode == tdcc_pkg::MODE_CLR_EDGE) && pri_valid));

	// equality sampled on the count tick, so a zero value fires on 0 to 1
	assign match1 = tick && (st_q.cnt == st_q.first);
	assign match2 = tick && (st_q.cnt == st_q.second);

	always_comb begin
		st_d = st_q;
		st_d.irq1 = 1'b0;
		st_d.irq2 = 1'b0;
		st_d.rdata = '0;

		// divider restarts whenever the counter stops or ticks
		if (!running || tick) begin
			st_d.div = '0;
		end else begin
			st_d.div = st_q.div + 3'h1;
		end

		// counter
		if (!running) begin
			st_d.cnt = tdcc_pkg::VALUE_RESET;
		end else if (clr_now) begin
			st_d.cnt = tdcc_pkg::VALUE_RESET;
		end else if (tick) begin
			if ((st_q.mode == tdcc_pkg::MODE_CLR_MATCH) && match1) begin
				st_d.cnt = tdcc_pkg::VALUE_RESET;
			end else begin
				st_d.cnt = st_q.cnt + tdcc_pkg::COUNT_ONE;
			end
		end

		// overflow: software write lands first so a wrap in the same cycle wins
		if (wr_mode) begin
			st_d.ovf = bus.wdata[tdcc_pkg::MODE_OVF];
			st_d.mode = bus.wdata[tdcc_pkg::MODE_LO +: 2];
		end
		if (tick && (st_q.cnt == tdcc_pkg::COUNT_MAX)) begin
			st_d.ovf = 1'b1;
		end

		// match requests only in compare role, one cycle each
		st_d.irq1 = match1 && !first_is_cap;
		st_d.irq2 = match2 && !second_is_cap;

		// value registers: a capture beats a same-cycle write
		if (wr_first) begin
			st_d.first = bus.wdata;
		end
		if (first_cap) begin
			st_d.first = st_q.cnt;
		end
		if (wr_second) begin
			st_d.second = bus.wdata;
		end
		if (second_cap) begin
			st_d.second = st_q.cnt;
		end

		if (wr_ctl) begin
			st_d.ctl = bus.wdata[3:0];
		end
		if (wr_pre) begin
			st_d.clk_sel = bus.wdata[tdcc_pkg::PRE_CLK_LO +: 2];
			st_d.pri_edge = bus.wdata[tdcc_pkg::PRE_PRI_LO +: 2];
			st_d.sec_edge = bus.wdata[tdcc_pkg::PRE_SEC_LO +: 2];
		end

		// timer output toggles on any match request, whether or not the pin is an output
		if (!running) begin
			st_d.tout = 1'b0;
		end else if (st_d.irq1 || st_d.irq2) begin
			st_d.tout = !st_q.tout;
		end
		// a register capturing from the secondary pin keeps it off the output
		st_d.toe = st_q.ctl[tdcc_pkg::CTL_OUT_EN]
			&& !(first_is_cap && !first_from_pri);

		// read data shows the pre-capture value if a capture coincides
		if (bus.rd) begin
			case (bus.addr)
				tdcc_pkg::IDX_FIRST: st_d.rdata = st_q.first;
				tdcc_pkg::IDX_SECOND: st_d.rdata = st_q.second;
				tdcc_pkg::IDX_COUNTER: st_d.rdata = st_q.cnt;
				tdcc_pkg::IDX_MODE: begin
					st_d.rdata[tdcc_pkg::MODE_LO +: 2] = st_q.mode;
					st_d.rdata[tdcc_pkg::MODE_OVF] = st_q.ovf;
				end
				tdcc_pkg::IDX_CTL: st_d.rdata[3:0] = st_q.ctl;
				tdcc_pkg::IDX_PRE: begin
					st_d.rdata[tdcc_pkg::PRE_CLK_LO +: 2] = st_q.clk_sel;
					st_d.rdata[tdcc_pkg::PRE_PRI_LO +: 2] = st_q.pri_edge;
					st_d.rdata[tdcc_pkg::PRE_SEC_LO +: 2] = st_q.sec_edge;
				end
				default: st_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata = st_q.rdata;
	assign first_match_irq = st_q.irq1;
	assign second_match_irq = st_q.irq2;
	assign timer_output_pin = st_q.tout;
	assign timer_output_oe = st_q.toe;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_stop_clears_count: assert property (
		(st_q.mode == tdcc_pkg::MODE_STOP) |=> (st_q.cnt == tdcc_pkg::VALUE_RESET)
	) else $error("counter not held at zero in stop mode");

	a_first_irq_cause: assert property (
		first_match_irq |-> $past(tick && (st_q.cnt == st_q.first) && !first_is_cap)
	) else $error("first match request without a compare match");

	a_second_irq_cause: assert property (
		second_match_irq |-> $past(tick && (st_q.cnt == st_q.second) && !second_is_cap)
	) else $error("second match request without a compare match");

	a_first_irq_fires: assert property (
		(tick && !first_is_cap && (st_q.cnt == st_q.first)) |=> first_match_irq
	) else $error("first match request missing after a match");

	a_overflow_sets: assert property (
		(tick && (st_q.cnt == tdcc_pkg::COUNT_MAX)) |=> st_q.ovf
	) else $error("overflow flag not set on wrap");

	a_first_capture_latch: assert property (
		first_cap |=> (st_q.first == $past(st_q.cnt))
	) else $error("first register did not latch the count");

	a_second_capture_latch: assert property (
		(second_is_cap && pri_valid) |=> (st_q.second == $past(st_q.cnt))
	) else $error("second register did not latch the count");

	a_count_increments: assert property (
		(tick && (st_q.mode == tdcc_pkg::MODE_FREE) && !clr_now && !bus.wr)
		|=> (st_q.cnt == $past(st_q.cnt) + tdcc_pkg::COUNT_ONE)
	) else $error("free-running counter did not advance");

	a_pin_not_shared: assert property (
		timer_output_oe |-> !$past(first_is_cap && !first_from_pri)
	) else $error("timer output driven while pin is a capture input");

	a_primary_opposite: assert property (
		(first_is_cap && first_from_pri && (st_q.pri_edge == tdcc_pkg::EDGE_RISE) && pri_rise)
		|-> !first_cap
	) else $error("primary capture taken on the wrong edge");

	a_first_cap_role: assert property (
		!first_is_cap |-> !first_cap
	) else $error("first register captured while in compare role");

	a_second_cap_role: assert property (
		!second_is_cap |-> !second_cap
	) else $error("second register captured while in compare role");

	a_first_irq_role: assert property (
		first_is_cap |=> !first_match_irq
	) else $error("first match request while first register captures");

	a_second_irq_role: assert property (
		second_is_cap |=> !second_match_irq
	) else $error("second match request while second register captures");

	a_first_value_held: assert property (
		(!wr_first && !first_cap) |=> $stable(st_q.first)
	) else $error("first register changed without write or capture");

	a_second_value_held: assert property (
		(!wr_second && !second_cap) |=> $stable(st_q.second)
	) else $error("second register changed without write or capture");

	a_second_rewrite: assert property (
		(wr_second && !second_cap) |=> (st_q.second == $past(bus.wdata))
	) else $error("second register write did not land");

	a_secondary_source: assert property (
		(first_is_cap && !first_from_pri) |-> (first_cap == sec_valid)
	) else $error("first register capture not following the secondary input");

	a_primary_none: assert property (
		(first_is_cap && first_from_pri && (st_q.pri_edge == tdcc_pkg::EDGE_BOTH))
		|-> !first_cap
	) else $error("primary capture taken with the both-edge code");

	a_primary_rise_cap: assert property (
		(first_is_cap && first_from_pri && (st_q.pri_edge == tdcc_pkg::EDGE_FALL) && pri_rise)
		|-> first_cap
	) else $error("primary rising capture missed");

	a_second_both: assert property (
		(second_is_cap && (st_q.pri_edge == tdcc_pkg::EDGE_BOTH) && (pri_rise || pri_fall))
		|-> second_cap
	) else $error("second register both-edge capture missed");

	a_zero_first_fires: assert property (
		(tick && !first_is_cap && (st_q.first == tdcc_pkg::VALUE_RESET)
			&& (st_q.cnt == tdcc_pkg::VALUE_RESET)) |=> first_match_irq
	) else $error("zero first value did not raise its request");

	a_zero_second_fires: assert property (
		(tick && !second_is_cap && (st_q.second == tdcc_pkg::VALUE_RESET)
			&& (st_q.cnt == tdcc_pkg::VALUE_RESET)) |=> second_match_irq
	) else $error("zero second value did not raise its request");

	a_stop_no_irq: assert property (
		(st_q.mode == tdcc_pkg::MODE_STOP) |=> (!first_match_irq && !second_match_irq)
	) else $error("match request raised in stop mode");

	a_reset_clears: assert property (
		$fell(sys_rst) |-> ((st_q.first == tdcc_pkg::VALUE_RESET)
			&& (st_q.second == tdcc_pkg::VALUE_RESET))
	) else $error("value registers not zero after reset");

	a_edge_clear: assert property (
		(running && (st_q.mode == tdcc_pkg::MODE_CLR_EDGE) && pri_valid)
		|=> (st_q.cnt == tdcc_pkg::VALUE_RESET)
	) else $error("counter not cleared on primary valid edge");

	a_match_clear: assert property (
		(tick && (st_q.mode == tdcc_pkg::MODE_CLR_MATCH) && (st_q.cnt == st_q.first))
		|=> (st_q.cnt == tdcc_pkg::VALUE_RESET)
	) else $error("counter not cleared on first register match");

	a_secondary_ignored: assert property (
		st_q.toe |-> !sec_valid
	) else $error("secondary input used while the pin drives the output");

	a_read_pre_capture: assert property (
		(bus.rd && (bus.addr == tdcc_pkg::IDX_FIRST)) |=> (rdata == $past(st_q.first))
	) else $error("first register read data wrong");

	c_first_match: cover property (first_match_irq);
	c_second_match: cover property (second_match_irq);
	c_first_capture: cover property (first_cap);
	c_second_capture: cover property (second_cap);
	c_wrap: cover property (tick && (st_q.cnt == tdcc_pkg::COUNT_MAX));
endmodule

/* File: tdcc_pin_model.sv */
// far-side model of the two timer input pins and the shared output pin
`timescale 1ns/1ps
module tdcc_pin_model (
	input wire logic clk,
	input wire logic timer_output_pin,
	input wire logic timer_output_oe,
	output logic primary_timer_input,
	output logic secondary_timer_input
);
	logic pri_q;
	logic sec_q;

	initial begin
		pri_q = 1'h0;
		sec_q = 1'h0;
	end

	task automatic set_pin(input bit pri, input bit lvl);
		@(posedge clk);
		if (pri) begin
			pri_q <= lvl;
		end else begin
			sec_q <= lvl;
		end
	endtask

	assign primary_timer_input = pri_q;
	// the shared pin carries the block's output while it drives, never both
	assign secondary_timer_input = timer_output_oe ? timer_output_pin : sec_q;
endmodule

/* File: tb_timer_dual_capture_compare.sv */
// self-checking bench for the dual capture/compare timer
`timescale 1ns/1ps
module tb_timer_dual_capture_compare;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	tdcc_pkg::tdcc_bus_t bus = '0;
	logic [15:0] rdata;
	logic pri;
	logic sec;
	logic irq1;
	logic irq2;
	logic tout;
	logic toe;
	int num_errors = 0;
	int tests_run = 0;
	logic [1:0] codes [3] = '{tdcc_pkg::EDGE_FALL, tdcc_pkg::EDGE_RISE, tdcc_pkg::EDGE_BOTH};

	always #5 clk = ~clk;

	tdcc_timer dut_u (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
		.primary_timer_input(pri), .secondary_timer_input(sec), .first_match_irq(irq1),
		.second_match_irq(irq2), .timer_output_pin(tout), .timer_output_oe(toe));

	tdcc_pin_model pins_u (.clk(clk), .timer_output_pin(tout), .timer_output_oe(toe),
		.primary_timer_input(pri), .secondary_timer_input(sec));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// whole 16-bit word per access, one strobe cycle each
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
		@(posedge clk);
		bus <= '0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
	endtask

	// stop first so value registers are never rewritten mid-count
	task automatic cfg(input logic [15:0] md, ctl, pre, f, s);
		wr(tdcc_pkg::IDX_MODE, 16'h0000);
		wr(tdcc_pkg::IDX_FIRST, f);
		wr(tdcc_pkg::IDX_SECOND, s);
		wr(tdcc_pkg::IDX_CTL, ctl);
		wr(tdcc_pkg::IDX_PRE, pre);
		wr(tdcc_pkg::IDX_MODE, md);
	endtask

	task automatic wait_irq(input bit two, input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (!((two ? irq2 : irq1) === 1'h1) && n < lim);
		if ((two ? irq2 : irq1) !== 1'h1) begin
			num_errors++;
			$display("[ERR] match request wait ran out");
			end_of_test();
		end
	endtask

	// move one pin, then see which value register took the count
	task automatic edge_try(input bit p, input bit lvl, input bit e1, input bit e2);
		logic [15:0] o1, o2, c0, c1, v1, v2;
		rd(tdcc_pkg::IDX_FIRST, o1);
		rd(tdcc_pkg::IDX_SECOND, o2);
		rd(tdcc_pkg::IDX_COUNTER, c0);
		pins_u.set_pin(p, lvl);
		repeat (6) @(posedge clk);
		rd(tdcc_pkg::IDX_COUNTER, c1);
		rd(tdcc_pkg::IDX_FIRST, v1);
		rd(tdcc_pkg::IDX_SECOND, v2);
		check("first value", 16'(e1 ? (v1 > c0 && v1 < c1) : v1 === o1), 16'h0001);
		check("second value", 16'(e2 ? (v2 > c0 && v2 < c1) : v2 === o2), 16'h0001);
	endtask

	task automatic t_reset();
		logic [15:0] d;
		rd(tdcc_pkg::IDX_FIRST, d);
		check("first after reset", d, tdcc_pkg::VALUE_RESET);
		rd(tdcc_pkg::IDX_SECOND, d);
		check("second after reset", d, tdcc_pkg::VALUE_RESET);
		rd(4'hF, d);
		check("unmapped read", d, 16'h0000);
		$display("reset test done");
	endtask

	task automatic t_compare();
		logic [15:0] d;
		int n;
		cfg(16'h0004, 16'h0000, 16'h0000, 16'h0005, 16'h0008);
		wait_irq(0, 40, n);
		check("output after first match", 16'(tout), 16'h0001);
		@(posedge clk);
		#1 check("first irq width", 16'(irq1), 16'h0000);
		wait_irq(1, 10, n);
		check("second irq spacing", 16'(n), 16'h0002);
		check("output after second match", 16'(tout), 16'h0000);
		rd(tdcc_pkg::IDX_FIRST, d);
		check("first held", d, 16'h0005);
		rd(tdcc_pkg::IDX_SECOND, d);
		check("second held", d, 16'h0008);
		$display("compare test done");
	endtask

	// nonzero first value, since the count clears on its match
	task automatic t_zero_second();
		int n;
		cfg(16'h000C, 16'h0000, 16'h0000, 16'h000A, 16'h0000);
		wait_irq(0, 40, n);
		wait_irq(1, 3, n);
		check("second after clear", 16'(n), 16'h0001);
		$display("zero second test done");
	endtask

	// zero first value: request on leaving zero, again only after a full wrap
	task automatic t_zero_first();
		logic [15:0] d;
		int n;
		cfg(16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h1000);
		wait_irq(0, 4, n);
		check("first zero start", 16'(n), 16'h0001);
		wait_irq(0, 70000, n);
		check("first zero wrap", 16'(n - 1), tdcc_pkg::COUNT_MAX);
		rd(tdcc_pkg::IDX_MODE, d);
		check("overflow flag", d, 16'h0005);
		$display("zero first test done");
	endtask

	task automatic t_primary();
		logic [1:0] c;
		for (int i = 0; i < 3; i++) begin
			c = codes[i];
			cfg(16'h0004, 16'h0007, {8'h00, 2'h0, c, 4'h0}, 16'h0000, 16'h0000);
			edge_try(1, 1, c == 2'h0, c != 2'h0);
			edge_try(1, 0, c == 2'h1, c != 2'h1);
		end
		$display("primary capture test done");
	endtask

	task automatic t_secondary();
		logic [1:0] c;
		for (int i = 0; i < 3; i++) begin
			c = codes[i];
			cfg(16'h0004, 16'h0009, {8'h00, c, 6'h00}, 16'h0000, 16'h0000);
			check("output enable", 16'(toe), 16'h0000);
			edge_try(0, 1, c != 2'h0, 0);
			edge_try(0, 0, c != 2'h1, 0);
		end
		$display("secondary capture test done");
	endtask

	// zero second value fires after an edge clear and after a one-shot clear
	task automatic t_clear_modes();
		int n;
		cfg(16'h0008, 16'h0000, 16'h0010, 16'h1000, 16'h0000);
		repeat (5) @(posedge clk);
		pins_u.set_pin(1, 1);
		wait_irq(1, 8, n);
		check("second after edge clear", 16'(n), 16'h0004);
		pins_u.set_pin(1, 0);
		wr(tdcc_pkg::IDX_MODE, 16'h0018);
		wait_irq(1, 4, n);
		check("second after one-shot", 16'(n), 16'h0001);
		$display("clear modes test done");
	endtask

	task automatic t_stop();
		logic [15:0] d;
		cfg(16'h0004, 16'h0008, 16'h0001, 16'h1000, 16'h1000);
		check("output enable on", 16'(toe), 16'h0001);
		repeat (20) @(posedge clk);
		rd(tdcc_pkg::IDX_COUNTER, d);
		check("divided count", d, 16'h000A);
		wr(tdcc_pkg::IDX_MODE, 16'h0000);
		repeat (3) @(posedge clk);
		rd(tdcc_pkg::IDX_COUNTER, d);
		check("counter stopped", d, 16'h0000);
		$display("stop test done");
	endtask

	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'h0;
		t_reset();
		t_compare();
		t_zero_second();
		t_zero_first();
		t_primary();
		t_secondary();
		t_clear_modes();
		t_stop();
		end_of_test();
	end
endmodule
